// ### compare_match_pkg.sv
// Constants and types shared by the compare match unit bank
package compare_match_pkg;

   // Bank shape
   localparam int NUM_UNITS = 7;
   localparam int NUM_TIMERS = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VALUE_W = 16;

   // Register byte addresses
   localparam logic [7:0] OFS_IRQ_PENDING = 8'h00;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h08;
   localparam logic [7:0] OFS_TIMER_SELECT_A = 8'h0c;
   localparam logic [7:0] OFS_TIMER_SELECT_B = 8'h10;
   localparam logic [7:0] OFS_UNIT_BASE = 8'h20;
   localparam logic [7:0] OFS_UNIT_LAST = 8'h8b;
   localparam int UNIT_STRIDE_SHIFT = 4;
   localparam logic [1:0] FIELD_CONTROL = 2'h0;
   localparam logic [1:0] FIELD_VALUE_LOW = 2'h1;
   localparam logic [1:0] FIELD_VALUE_HIGH = 2'h2;

   // Implemented bits of the byte-wide registers
   localparam logic [7:0] CONTROL_MASK = 8'h3f;
   localparam logic [7:0] SELECT_A_MASK = 8'hd7;
   localparam logic [7:0] SELECT_B_MASK = 8'h17;
   localparam logic [7:0] PENDING_HW_MASK = 8'hfe;
   localparam int FIRST_UNIT_BIT = 1;

   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_VALUE = 16'h0000;

   // Mode field codes for compare use
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_DRIVE_HIGH = 4'h8;
   localparam logic [3:0] MODE_DRIVE_LOW = 4'h9;
   localparam logic [3:0] MODE_SOFT_IRQ = 4'ha;
   localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;

   // Timer identities inside the count bundle
   localparam logic [1:0] TIMER_1 = 2'h0;
   localparam logic [1:0] TIMER_3 = 2'h1;
   localparam logic [1:0] TIMER_5 = 2'h2;
   localparam logic [1:0] TIMER_7 = 2'h3;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [1:0] duty_low_bits;
      logic [3:0] mode_field;
   } unit_control_t;

   typedef struct packed {
      logic [15:0] timer7;
      logic [15:0] timer5;
      logic [15:0] timer3;
      logic [15:0] timer1;
   } timer_counts_t;

endpackage

// ### compare_match_unit.sv
// Compare match unit bank, units four to ten, with AXI4-Lite registers
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module compare_match_unit (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer counts and special event resets
   input wire compare_match_pkg::timer_counts_t timer_counts,
   output logic [3:0] timer_reset,
   // Port side of each unit pin, bit 0 is unit four
   input wire logic [6:0] port_direction_bit,
   input wire logic [6:0] port_io_latch,
   output logic [6:0] unit_pin_out,
   output logic [6:0] unit_pin_oe,
   // Interrupt
   output logic [7:0] irq_priority,
   output logic irq
);

   localparam int N = compare_match_pkg::NUM_UNITS;

   // Maps a unit's select bits to a timer; invalid for reserved codes
   function automatic logic [2:0] pick_timer(input int unit, input logic [1:0] sel);
      logic [1:0] alt;
      logic two_bit;
      alt = (unit == 0) ? compare_match_pkg::TIMER_3 :
            (unit <= 3) ? compare_match_pkg::TIMER_5 : compare_match_pkg::TIMER_7;
      two_bit = (unit == 0) || (unit == 4);
      if (sel == 2'h0) begin
         pick_timer = {1'b1, compare_match_pkg::TIMER_1};
      // Reserved code: no time base, so the unit never matches
      end else if (two_bit && sel == 2'h3) begin
         pick_timer = {1'b0, compare_match_pkg::TIMER_1};
      end else begin
         pick_timer = {1'b1, alt};
      end
   endfunction

   // Selects one timer count from the bundle
   function automatic logic [15:0] count_of(input compare_match_pkg::timer_counts_t c,
                                            input logic [1:0] id);
      unique case (id)
         compare_match_pkg::TIMER_1: count_of = c.timer1;
         compare_match_pkg::TIMER_3: count_of = c.timer3;
         compare_match_pkg::TIMER_5: count_of = c.timer5;
         compare_match_pkg::TIMER_7: count_of = c.timer7;
      endcase
   endfunction

   // Address decode shared by read and write paths
   function automatic logic is_unit_addr(input logic [7:0] a);
      is_unit_addr = (a >= compare_match_pkg::OFS_UNIT_BASE) &&
                     (a <= compare_match_pkg::OFS_UNIT_LAST) && (a[3:2] != 2'h3);
   endfunction

   function automatic logic [2:0] unit_slot(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - compare_match_pkg::OFS_UNIT_BASE;
      unit_slot = rel[6:4];
   endfunction

   // Write channel holding registers
   logic aw_full_q, aw_full_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic w_full_q, w_full_d;
   logic [7:0] w_data_q, w_data_d;
   logic w_lane_q, w_lane_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   // Read channel
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   // Shared registers
   logic [7:0] pending_q, pending_d;
   logic [7:0] enable_q, enable_d;
   logic [7:0] priority_q, priority_d;
   logic [7:0] select_a_q, select_a_d;
   logic [7:0] select_b_q, select_b_d;
   logic [3:0] timer_reset_q, timer_reset_d;

   // Per unit wires
   logic [1:0] unit_sel [N];
   logic [7:0] unit_control_rd [N];
   logic [15:0] unit_value_rd [N];
   logic [N-1:0] unit_match;
   logic [N-1:0] unit_special;
   logic [1:0] unit_timer_id [N];

   // Write decode
   // Held halves wait while an earlier response is still unanswered
   wire do_write = aw_full_q && w_full_q && !bvalid_q;
   wire wr_lane = do_write && w_lane_q;
   wire wr_unit = is_unit_addr(aw_addr_q);
   wire [2:0] wr_slot = unit_slot(aw_addr_q);
   wire [1:0] wr_field = aw_addr_q[3:2];
   wire wr_pending = wr_lane && (aw_addr_q == compare_match_pkg::OFS_IRQ_PENDING);
   wire wr_enable = wr_lane && (aw_addr_q == compare_match_pkg::OFS_IRQ_ENABLE);
   wire wr_priority = wr_lane && (aw_addr_q == compare_match_pkg::OFS_IRQ_PRIORITY);
   wire wr_select_a = wr_lane && (aw_addr_q == compare_match_pkg::OFS_TIMER_SELECT_A);
   wire wr_select_b = wr_lane && (aw_addr_q == compare_match_pkg::OFS_TIMER_SELECT_B);
   wire wr_mapped = wr_unit || (aw_addr_q == compare_match_pkg::OFS_IRQ_PENDING) ||
                    (aw_addr_q == compare_match_pkg::OFS_IRQ_ENABLE) ||
                    (aw_addr_q == compare_match_pkg::OFS_IRQ_PRIORITY) ||
                    (aw_addr_q == compare_match_pkg::OFS_TIMER_SELECT_A) ||
                    (aw_addr_q == compare_match_pkg::OFS_TIMER_SELECT_B);

   // Write channel: address and data accepted in either order
   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign aw_full_d = do_write ? 1'b0 : (aw_full_q || s_axi_awvalid);
   assign aw_addr_d = (s_axi_awvalid && !aw_full_q) ? s_axi_awaddr : aw_addr_q;
   assign w_full_d = do_write ? 1'b0 : (w_full_q || s_axi_wvalid);
   assign w_data_d = (s_axi_wvalid && !w_full_q) ? s_axi_wdata[7:0] : w_data_q;
   assign w_lane_d = (s_axi_wvalid && !w_full_q) ? s_axi_wstrb[0] : w_lane_q;
   assign bvalid_d = do_write || (bvalid_q && !s_axi_bready);
   // Unmapped writes change nothing and answer with an error
   assign bresp_d = do_write ?
                    (wr_mapped ? compare_match_pkg::RESP_OKAY : compare_match_pkg::RESP_SLVERR) :
                    bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Timer select registers, unimplemented bits held at zero
   assign select_a_d = wr_select_a ? (w_data_q & compare_match_pkg::SELECT_A_MASK) :
                       select_a_q;
   assign select_b_d = wr_select_b ? (w_data_q & compare_match_pkg::SELECT_B_MASK) :
                       select_b_q;
   assign unit_sel[0] = select_a_q[1:0];
   assign unit_sel[1] = {1'b0, select_a_q[2]};
   assign unit_sel[2] = {1'b0, select_a_q[4]};
   assign unit_sel[3] = select_a_q[7:6];
   assign unit_sel[4] = select_b_q[1:0];
   assign unit_sel[5] = {1'b0, select_b_q[2]};
   assign unit_sel[6] = {1'b0, select_b_q[4]};

   genvar k;
   generate
      for (k = 0; k < N; k++) begin : g_unit
         compare_match_pkg::unit_control_t control_q, control_d;
         logic [15:0] value_q, value_d;
         logic latch_q, latch_d;
         logic equal_q;
         logic pin_q, oe_q;
         wire hit = wr_lane && wr_unit && (wr_slot == 3'(k));
         wire wr_control = hit && (wr_field == compare_match_pkg::FIELD_CONTROL);
         wire wr_low = hit && (wr_field == compare_match_pkg::FIELD_VALUE_LOW);
         wire wr_high = hit && (wr_field == compare_match_pkg::FIELD_VALUE_HIGH);
         wire [3:0] mode = control_q.mode_field;
         wire [2:0] timer_pick = pick_timer(k, unit_sel[k]);
         wire compare_mode = (mode == compare_match_pkg::MODE_TOGGLE) ||
                             (mode == compare_match_pkg::MODE_DRIVE_HIGH) ||
                             (mode == compare_match_pkg::MODE_DRIVE_LOW) ||
                             (mode == compare_match_pkg::MODE_SOFT_IRQ) ||
                             (mode == compare_match_pkg::MODE_SPECIAL_EVENT);
         // Soft interrupt and special event leave the pin to the port
         wire drives_pin = (mode == compare_match_pkg::MODE_TOGGLE) ||
                           (mode == compare_match_pkg::MODE_DRIVE_HIGH) ||
                           (mode == compare_match_pkg::MODE_DRIVE_LOW);
         // Counts must be clocked here; an unsynchronised count can miss
         wire [15:0] count = count_of(timer_counts, timer_pick[1:0]);
         wire equal_now = compare_mode && timer_pick[2] && (count == value_q);
         // Edge on equality, so a stopped timer does not refire
         wire match = equal_now && !equal_q;
         // Bits 7:6 dropped here so they always read back as zero
         wire [7:0] wr_byte = w_data_q & compare_match_pkg::CONTROL_MASK;

         assign control_d = wr_control ? wr_byte[5:0] : control_q;
         // Bytes land one at a time; no atomic 16-bit update
         assign value_d = wr_low ? {value_q[15:8], w_data_q} :
                          wr_high ? {w_data_q, value_q[7:0]} : value_q;
         // Mode writes preset the latch so set and clear modes start opposite
         assign latch_d = (wr_control && wr_byte == compare_match_pkg::RESET_BYTE) ? 1'b0 :
                          (wr_control && wr_byte[3:0] == compare_match_pkg::MODE_DRIVE_HIGH) ?
                          1'b0 :
                          (wr_control && wr_byte[3:0] == compare_match_pkg::MODE_DRIVE_LOW) ?
                          1'b1 :
                          !match ? latch_q :
                          (mode == compare_match_pkg::MODE_DRIVE_HIGH) ? 1'b1 :
                          (mode == compare_match_pkg::MODE_DRIVE_LOW) ? 1'b0 :
                          (mode == compare_match_pkg::MODE_TOGGLE) ? !latch_q :
                          latch_q;

         assign unit_match[k] = match;
         // Every unit can raise the special event, unit four included
         assign unit_special[k] = match &&
                                  (mode == compare_match_pkg::MODE_SPECIAL_EVENT);
         assign unit_timer_id[k] = timer_pick[1:0];
         assign unit_control_rd[k] = {2'b00, control_q};
         assign unit_value_rd[k] = value_q;
         assign unit_pin_out[k] = pin_q;
         assign unit_pin_oe[k] = oe_q;

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               control_q <=
                  compare_match_pkg::unit_control_t'(compare_match_pkg::RESET_BYTE[5:0]);
               value_q <= compare_match_pkg::RESET_VALUE;
               latch_q <= 1'b0;
               equal_q <= 1'b0;
               pin_q <= 1'b0;
               oe_q <= 1'b0;
            end else begin
               control_q <= control_d;
               value_q <= value_d;
               latch_q <= latch_d;
               equal_q <= equal_now;
               // Pin trails the latch by a cycle, traded for a flop output
               pin_q <= drives_pin ? latch_q : port_io_latch[k];
               // Pin only driven once software made it an output
               oe_q <= drives_pin && !port_direction_bit[k];
            end
         end
      end
   endgenerate

   // Special event resets the count of each timer a unit is tied to
   // Units sharing one timer merge into a single reset pulse
   always_comb begin
      timer_reset_d = 4'h0;
      for (int u = 0; u < N; u++) begin
         if (unit_special[u]) begin
            timer_reset_d[unit_timer_id[u]] = 1'b1;
         end
      end
   end
   assign timer_reset = timer_reset_q;

   // Flags: set wins over a same-cycle clear; bit 0 belongs to unit three
   wire [7:0] flag_set = {unit_match, 1'b0} & compare_match_pkg::PENDING_HW_MASK;
   wire [7:0] flag_clear = wr_pending ? w_data_q : 8'h00;
   assign pending_d = (pending_q & ~flag_clear) | flag_set;
   assign enable_d = wr_enable ? w_data_q : enable_q;
   assign priority_d = wr_priority ? w_data_q : priority_q;
   assign irq = |(pending_q & enable_q);
   assign irq_priority = priority_q;

   // Read channel
   // Address decoded straight off the bus in the cycle it is taken
   wire take_read = s_axi_arvalid && !rvalid_q;
   wire rd_unit = is_unit_addr(s_axi_araddr);
   wire [2:0] rd_slot = unit_slot(s_axi_araddr);
   wire [1:0] rd_field = s_axi_araddr[3:2];
   // Slot past the last unit only occurs when this result is unused
   wire [7:0] rd_unit_byte = (rd_field == compare_match_pkg::FIELD_CONTROL) ?
                             unit_control_rd[rd_slot] :
                             (rd_field == compare_match_pkg::FIELD_VALUE_LOW) ?
                             unit_value_rd[rd_slot][7:0] : unit_value_rd[rd_slot][15:8];
   logic [7:0] rd_byte;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      rd_byte = 8'h00;
      if (rd_unit) begin
         rd_byte = rd_unit_byte;
      end else if (s_axi_araddr == compare_match_pkg::OFS_IRQ_PENDING) begin
         rd_byte = pending_q;
      end else if (s_axi_araddr == compare_match_pkg::OFS_IRQ_ENABLE) begin
         rd_byte = enable_q;
      end else if (s_axi_araddr == compare_match_pkg::OFS_IRQ_PRIORITY) begin
         rd_byte = priority_q;
      end else if (s_axi_araddr == compare_match_pkg::OFS_TIMER_SELECT_A) begin
         rd_byte = select_a_q;
      end else if (s_axi_araddr == compare_match_pkg::OFS_TIMER_SELECT_B) begin
         rd_byte = select_b_q;
      end else begin
         rd_ok = 1'b0;
      end
   end
   // One read at a time; the next address waits for the answer
   assign s_axi_arready = !rvalid_q;
   assign rvalid_d = take_read || (rvalid_q && !s_axi_rready);
   // Every register is one byte, so the upper read data stays zero
   assign rdata_d = take_read ? {24'h000000, rd_byte} : rdata_q;
   assign rresp_d = take_read ?
                    (rd_ok ? compare_match_pkg::RESP_OKAY : compare_match_pkg::RESP_SLVERR) :
                    rresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_full_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= compare_match_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= compare_match_pkg::RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         aw_addr_q <= aw_addr_d;
         w_full_q <= w_full_d;
         w_data_q <= w_data_d;
         w_lane_q <= w_lane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_q <= compare_match_pkg::RESET_BYTE;
         enable_q <= compare_match_pkg::RESET_BYTE;
         priority_q <= compare_match_pkg::RESET_BYTE;
         select_a_q <= compare_match_pkg::RESET_BYTE;
         select_b_q <= compare_match_pkg::RESET_BYTE;
         timer_reset_q <= 4'h0;
      end else begin
         pending_q <= pending_d;
         enable_q <= enable_d;
         priority_q <= priority_d;
         select_a_q <= select_a_d;
         select_b_q <= select_b_d;
         timer_reset_q <= timer_reset_d;
      end
   end

endmodule // compare_match_unit

`default_nettype wire

// ### compare_match_unit_assertions.sv
// Port checker for the compare match unit bank
`timescale 1ns/1ps
`default_nettype none
module compare_match_unit_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins, timers and interrupt
   input wire logic [3:0] timer_reset,
   input wire logic [6:0] port_direction_bit,
   input wire logic [6:0] unit_pin_oe,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   both_halves_a: assert property ($rose(s_axi_bvalid) |->
      !$past(s_axi_awready) && !$past(s_axi_wready))
      else $error("write answered before both halves were taken");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered in one cycle");
   aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address slot not held after being taken");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above the byte not zero");
   pin_input_a: assert property ((unit_pin_oe & $past(port_direction_bit)) == 7'h00)
      else $error("pin driven while its direction is input");
   reset_quiet_a: assert property ($rose(aresetn) |->
      !irq && timer_reset == 4'h0 && unit_pin_oe == 7'h00)
      else $error("outputs not quiet after reset");

   // Main scenarios reached
   cover property (timer_reset != 4'h0);
   cover property ($rose(irq));
   cover property (s_axi_bvalid && s_axi_bresp == compare_match_pkg::RESP_SLVERR);
   cover property (unit_pin_oe[0]);
endmodule // compare_match_unit_checker

bind compare_match_unit compare_match_unit_checker checker_i (.*);
`default_nettype wire

// ### pin_load.sv
// External load on the unit pins
`timescale 1ns/1ps
`default_nettype none
module pin_load (
   // Pin drivers
   input wire logic [6:0] unit_pin_out,
   input wire logic [6:0] unit_pin_oe,
   // Resolved pin levels
   output logic [6:0] pin_level
);
   // Pull-down, so a released pin never shows its last driven value
   assign pin_level = unit_pin_oe & unit_pin_out;
endmodule // pin_load
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the compare match unit bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic aclk, aresetn, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, irq_priority;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, timer_reset;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   compare_match_pkg::timer_counts_t timer_counts;
   logic [6:0] port_direction_bit, port_io_latch, unit_pin_out, unit_pin_oe, pin_level;
   int fails, num_checks;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [3:0] tq[$];

   compare_match_unit uut (.*);
   pin_load load_i (.*);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Results are judged where they appear, oldest note first
   always @(negedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) check("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready) check("bresp", bq.pop_front(), s_axi_bresp);
      if (timer_reset != 4'h0) check("timer reset", tq.pop_front(), timer_reset);
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp = 2'b00);
      logic aw, w, b;
      bq.push_back(resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp = 2'b00);
      logic ar, r;
      rq.push_back({resp, 24'h000000, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!r);
      s_axi_rready <= 1'b0;
   endtask

   initial begin
      logic [15:0] v;
      logic [7:0] x, a;
      // Toggle follows drive high, so only the zero write can clear its latch
      logic [3:0] modes [4] = '{4'h8, 4'h2, 4'h9, 4'ha};
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h1;
      timer_counts = '0;
      port_direction_bit = 7'h7e;
      fails = 0;
      num_checks = 0;
      void'($urandom(32'h6ddd7388));
      port_io_latch = 7'($urandom);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(compare_match_pkg::OFS_IRQ_PENDING, 8'h00);
      // Mode bits 3 and 1 stay clear so no compare mode fires a stray match
      for (int k = 0; k < 7; k++) begin
         x = 8'($urandom) & 8'hf5;
         a = 8'h20 + 8'(16 * k);
         rd(a, 8'h00);
         wr(a, x);
         rd(a, x & compare_match_pkg::CONTROL_MASK);
         wr(a + 8'h04, x);
         wr(a + 8'h08, ~x);
         rd(a + 8'h04, x);
         rd(a + 8'h08, ~x);
         wr(a, 8'h00);
      end
      x = 8'($urandom);
      wr(compare_match_pkg::OFS_TIMER_SELECT_A, x);
      rd(compare_match_pkg::OFS_TIMER_SELECT_A, x & compare_match_pkg::SELECT_A_MASK);
      wr(compare_match_pkg::OFS_TIMER_SELECT_B, x);
      rd(compare_match_pkg::OFS_TIMER_SELECT_B, x & compare_match_pkg::SELECT_B_MASK);
      wr(compare_match_pkg::OFS_IRQ_PRIORITY, x);
      rd(compare_match_pkg::OFS_IRQ_PRIORITY, x);
      check("priority", x, irq_priority);
      wr(8'h2c, x, compare_match_pkg::RESP_SLVERR);
      rd(8'h2c, 8'h00, compare_match_pkg::RESP_SLVERR);
      wr(compare_match_pkg::OFS_TIMER_SELECT_A, 8'h00);
      wr(compare_match_pkg::OFS_TIMER_SELECT_B, 8'h00);
      wr(compare_match_pkg::OFS_IRQ_ENABLE, 8'h02);
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom) | 16'h8000;
         wr(8'h20, 8'h00);
         wr(8'h24, v[7:0]);
         wr(8'h28, v[15:8]);
         @(posedge aclk);
         timer_counts.timer1 <= v ^ 16'h0001;
         timer_counts.timer7 <= 16'($urandom);
         wr(8'h20, {4'h0, modes[i]});
         repeat (3) @(posedge aclk);
         @(negedge aclk);
         check("pin before", modes[i] == 4'h9, pin_level[0]);
         @(posedge aclk);
         timer_counts.timer1 <= v;
         repeat (4) @(posedge aclk);
         @(negedge aclk);
         check("pin out", modes[i] == 4'ha ? port_io_latch[0] : modes[i] != 4'h9,
               unit_pin_out[0]);
         check("pin drive", modes[i] != 4'ha, unit_pin_oe[0]);
         check("irq raised", 1'b1, irq);
         rd(compare_match_pkg::OFS_IRQ_PENDING, 8'h02);
         wr(compare_match_pkg::OFS_IRQ_ENABLE, 8'h00);
         check("irq masked", 1'b0, irq);
         wr(compare_match_pkg::OFS_IRQ_ENABLE, 8'h02);
         wr(compare_match_pkg::OFS_IRQ_PENDING, 8'h02);
         check("irq cleared", 1'b0, irq);
         rd(compare_match_pkg::OFS_IRQ_PENDING, 8'h00);
      end
      // Both non-reserved codes that pick the second timer
      for (int s = 1; s < 3; s++) begin
         v = 16'($urandom) | 16'h8000;
         wr(compare_match_pkg::OFS_TIMER_SELECT_A, 8'(s));
         wr(8'h24, v[7:0]);
         wr(8'h28, v[15:8]);
         @(posedge aclk);
         timer_counts.timer3 <= v ^ 16'h0001;
         wr(8'h20, {4'h0, compare_match_pkg::MODE_SPECIAL_EVENT});
         tq.push_back(4'h2);
         @(posedge aclk);
         timer_counts.timer3 <= v;
         repeat (4) @(posedge aclk);
         timer_counts.timer3 <= 16'h0000;
         rd(compare_match_pkg::OFS_IRQ_PENDING, 8'h02);
         wr(compare_match_pkg::OFS_IRQ_PENDING, 8'h02);
         wr(8'h20, 8'h00);
      end
      repeat (4) @(posedge aclk);
      conclude();
   end

   // Whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      conclude();
   end
endmodule // testbench
`default_nettype wire
